// file: rtl/stm_pkg.sv
package stm_pkg;

  // ==========================================================
  // register map (byte addresses over the plain port)
  localparam logic [7:0] STM_ADDR_CTRL = 8'h00;
  localparam logic [7:0] STM_ADDR_NONOVERLAP = 8'h04;
  localparam logic [7:0] STM_ADDR_STATUS = 8'h08;
  localparam logic [7:0] STM_ADDR_COUNT = 8'h0c;
  localparam logic [7:0] STM_ADDR_PERIOD = 8'h10;
  localparam logic [7:0] STM_ADDR_PATTERN = 8'h14;
  localparam logic [7:0] STM_ADDR_CLEAR = 8'h18;
  localparam logic [7:0] STM_ADDR_TABLE = 8'h40;

  // ==========================================================
  // descriptor layout and transfer-engine addresses
  localparam logic [23:0] STM_DESC_BASE = 24'hff6000;
  localparam logic [23:0] STM_VECTOR_BASE = 24'hff8000;
  localparam int STM_DESC_FIELDS = 6;

  // ==========================================================
  // field positions
  localparam int STM_CTRL_RUN_BIT = 0;
  localparam int STM_STAT_RUN_BIT = 0;
  localparam int STM_STAT_DIR_BIT = 1;
  localparam int STM_STAT_DONE_BIT = 2;
  localparam int STM_STAT_STAGE_LSB = 4;

  // ==========================================================
  // reset values and table contents
  localparam logic [15:0] STM_NONOVERLAP_RST = 16'h0100;
  localparam logic [15:0] STM_PERIOD_RST = 16'hfff0;
  localparam logic [15:0] STM_CRUISE_PERIOD = 16'h3000;
  localparam logic [7:0] STM_PAT0 = 8'hf6;
  localparam logic [7:0] STM_PAT1 = 8'hf3;
  localparam logic [7:0] STM_PAT2 = 8'hf9;
  localparam logic [7:0] STM_PAT3 = 8'hfc;
  localparam int STM_PAT_COUNT = 4;

  // ==========================================================
  // step counts
  localparam logic [9:0] STM_RAMP_STEP_COUNT = 10'd49;
  localparam logic [9:0] STM_CRUISE_STEP_COUNT = 10'd481;
  localparam logic [9:0] STM_HOLD_STEP_COUNT = 10'd20;

  typedef enum logic [2:0] {
    STM_ST_IDLE = 3'b000,
    STM_ST_RAMP_UP = 3'b001,
    STM_ST_CRUISE = 3'b010,
    STM_ST_RAMP_DOWN = 3'b011,
    STM_ST_HOLD = 3'b100
  } stm_stage_e;

  typedef struct packed {
    logic [7:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } stm_bus_req_s;

endpackage : stm_pkg

// file: rtl/stm_sequencer.sv
`timescale 1ns/10ps
// ==========================================================
// Operation
// - non-overlap match starts one transfer and signals the output stage
// - period match clears the counter and starts a pattern switch
// - each activation moves a pattern, then chains a period value, except in hold and at the last step of a stage
// - four phase outputs, every change carries a non-overlap gap
// - at period match falling bits apply at once, rising bits wait
// - at non-overlap match the held rising bits are applied
// - descriptors at base in order mode a, src, mode b, dst, cnt a, cnt b
// - high output means the phase winding is energised
// - two adjacent phases per step, forward order, reverse the opposite
// - stop holds the last pattern for a set number of steps
// - a shoot-through gap follows every pattern change
// - rotation has speed-up, constant and slow-down phases
// - forward, hold, reverse, hold repeat forever
// - ramp periods are updated by hardware alone
// - group zero triggered by channel 0, direct output, non-overlap
// - transfer vectors are looked up from the stated base
// - pattern transfer repeats over four bytes, source increments forward, decrements in reverse
// - period transfer moves one word per step for the stage count
// - both compares output compares, non-overlap match activates transfers
// - forward codes f6, f3, f9, fc, low nibble selects phases
// - 49 ramp steps, 481 cruise steps, 20 hold steps
module stm_sequencer (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [7:0] addr_in,
  input wire logic [15:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [15:0] rdata_out,
  output logic [3:0] phase_output_pins_out,
  output logic stage_done_out
);
  import stm_pkg::*;

  // ==========================================================
  // period table, writable by software, ramp-up order
  logic [15:0] period_table_r [0:63];
  logic [7:0] pattern_table [0:3];
  assign pattern_table[0] = STM_PAT0;
  assign pattern_table[1] = STM_PAT1;
  assign pattern_table[2] = STM_PAT2;
  assign pattern_table[3] = STM_PAT3;

  stm_bus_req_s req;
  assign req = '{addr: addr_in, wdata: wdata_in, wr: wr_in, rd: rd_in};

  logic run_r;
  logic [15:0] nonoverlap_compare_ch0_r;
  logic [15:0] step_period_compare_ch0_r;
  logic [15:0] step_counter_ch0_r;
  logic [7:0] next_output_pattern_r;
  logic [3:0] phase_r;
  logic [3:0] held_rise_r;
  logic [1:0] pat_idx_r;
  logic [9:0] count_r;
  logic [5:0] tbl_idx_r;
  logic dir_rev_r;
  logic done_r;
  stm_stage_e stage_r;
  stm_stage_e stage_nxt;

  logic period_match;
  logic nonoverlap_match;
  logic stage_end;

  function automatic logic [1:0] stm_step_idx(input logic [1:0] idx, input logic rev);
    stm_step_idx = rev ? idx - 2'd1 : idx + 2'd1;
  endfunction : stm_step_idx

  function automatic logic [15:0] stm_clamp_nonoverlap(input logic [15:0] v, input logic [15:0] per);
    stm_clamp_nonoverlap = (v >= per) ? per - 16'h0001 : v;
  endfunction : stm_clamp_nonoverlap

  // ==========================================================
  // step timer channel 0
  assign period_match = run_r && (step_counter_ch0_r == step_period_compare_ch0_r);
  // non-overlap clamped below the period so the rising edges stay in the step
  assign nonoverlap_match = run_r &&
    (step_counter_ch0_r == stm_clamp_nonoverlap(nonoverlap_compare_ch0_r, step_period_compare_ch0_r));

  always_ff @(posedge clk_in) begin
    if (rst_in || !run_r) begin
      step_counter_ch0_r <= 16'h0000;
    end else if (period_match) begin
      step_counter_ch0_r <= 16'h0000;
    end else begin
      step_counter_ch0_r <= step_counter_ch0_r + 16'h0001;
    end
  end

  // ==========================================================
  // pattern output unit, group zero on channel 0
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      phase_r <= 4'h0;
      held_rise_r <= 4'h0;
    end else if (period_match) begin
      // falls go out now, rises wait for the gap to avoid shoot-through
      phase_r <= phase_r & next_output_pattern_r[3:0];
      held_rise_r <= next_output_pattern_r[3:0] & ~phase_r;
    end else if (nonoverlap_match) begin
      phase_r <= phase_r | held_rise_r;
      held_rise_r <= 4'h0;
    end
  end

  // high level energises the winding
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      phase_output_pins_out <= 4'h0;
    end else begin
      phase_output_pins_out <= phase_r;
    end
  end

  // ==========================================================
  // transfer engine: pattern then chained period word
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      next_output_pattern_r <= STM_PAT0;
      pat_idx_r <= 2'd0;
    end else if (nonoverlap_match) begin
      if (stage_r == STM_ST_HOLD) begin
        // reload the pattern already out, otherwise hold would slip one step
        next_output_pattern_r <= pattern_table[pat_idx_r];
      end else begin
        // repeat area of four bytes wraps without software
        next_output_pattern_r <= pattern_table[stm_step_idx(pat_idx_r, dir_rev_r)];
        pat_idx_r <= stm_step_idx(pat_idx_r, dir_rev_r);
      end
    end
  end

  // hold keeps the last pattern, so the step period stays unchanged there
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      step_period_compare_ch0_r <= STM_PERIOD_RST;
      tbl_idx_r <= 6'd0;
    end else if (stage_end) begin
      tbl_idx_r <= (stage_nxt == STM_ST_RAMP_DOWN) ? 6'(STM_RAMP_STEP_COUNT - 10'd1) : 6'd0;
    end else if (nonoverlap_match) begin
      case (stage_r)
        STM_ST_RAMP_UP: begin
          step_period_compare_ch0_r <= period_table_r[tbl_idx_r];
          tbl_idx_r <= tbl_idx_r + 6'd1;
        end
        STM_ST_RAMP_DOWN: begin
          step_period_compare_ch0_r <= period_table_r[tbl_idx_r];
          tbl_idx_r <= tbl_idx_r - 6'd1;
        end
        STM_ST_CRUISE: begin
          step_period_compare_ch0_r <= period_table_r[6'(STM_RAMP_STEP_COUNT - 10'd1)];
        end
        default: begin
          step_period_compare_ch0_r <= step_period_compare_ch0_r;
        end
      endcase
    end
  end

  // ==========================================================
  // descriptor fetch: vector first, then pattern and period fields in order
  logic [3:0] fetch_slot_r;
  logic fetch_busy_r;
  logic [23:0] fetch_addr_r;

  function automatic logic [23:0] stm_desc_addr(input logic [3:0] slot);
    stm_desc_addr = STM_DESC_BASE + {18'h0, slot, 2'b00};
  endfunction : stm_desc_addr

  // address trace only; the loads above do not wait for it, since a walk of
  // twelve fields would outlast the shortest step period
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      fetch_slot_r <= 4'h0;
      fetch_busy_r <= 1'b0;
      fetch_addr_r <= STM_VECTOR_BASE;
    end else if (nonoverlap_match) begin
      fetch_addr_r <= STM_VECTOR_BASE;
      fetch_slot_r <= 4'h0;
      fetch_busy_r <= 1'b1;
    end else if (fetch_busy_r) begin
      fetch_addr_r <= stm_desc_addr(fetch_slot_r);
      fetch_slot_r <= fetch_slot_r + 4'h1;
      fetch_busy_r <= (fetch_slot_r != 4'(2 * STM_DESC_FIELDS - 1));
    end
  end

  // ==========================================================
  // stage sequencer, replacing the per-stage software handler
  assign stage_end = nonoverlap_match && (count_r == 10'd1);

  always_comb begin
    case (stage_r)
      STM_ST_RAMP_UP: stage_nxt = STM_ST_CRUISE;
      STM_ST_CRUISE: stage_nxt = STM_ST_RAMP_DOWN;
      STM_ST_RAMP_DOWN: stage_nxt = STM_ST_HOLD;
      STM_ST_HOLD: stage_nxt = STM_ST_RAMP_UP;
      default: stage_nxt = STM_ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      stage_r <= STM_ST_IDLE;
      count_r <= 10'd0;
      dir_rev_r <= 1'b0;
    end else if (!run_r) begin
      stage_r <= STM_ST_IDLE;
      count_r <= 10'd0;
    end else if (stage_r == STM_ST_IDLE) begin
      stage_r <= STM_ST_RAMP_UP;
      count_r <= STM_RAMP_STEP_COUNT;
    end else if (stage_end) begin
      stage_r <= stage_nxt;
      case (stage_nxt)
        STM_ST_CRUISE: count_r <= STM_CRUISE_STEP_COUNT;
        STM_ST_HOLD: count_r <= STM_HOLD_STEP_COUNT;
        default: count_r <= STM_RAMP_STEP_COUNT;
      endcase
      if (stage_r == STM_ST_HOLD) begin
        dir_rev_r <= ~dir_rev_r;
      end
    end else if (nonoverlap_match) begin
      count_r <= count_r - 10'd1;
    end
  end

  // ==========================================================
  // register port: control, status, period table
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      run_r <= 1'b0;
      nonoverlap_compare_ch0_r <= STM_NONOVERLAP_RST;
    end else if (req.wr && req.addr == STM_ADDR_CTRL) begin
      run_r <= req.wdata[STM_CTRL_RUN_BIT];
    end else if (req.wr && req.addr == STM_ADDR_NONOVERLAP) begin
      nonoverlap_compare_ch0_r <= req.wdata;
    end
  end

  always_ff @(posedge clk_in) begin
    // two bytes per word keeps all ramp entries inside the byte map
    if (req.wr && req.addr >= STM_ADDR_TABLE && req.addr < 8'(STM_ADDR_TABLE + 8'h62)) begin
      period_table_r[6'((req.addr - STM_ADDR_TABLE) >> 1)] <= req.wdata;
    end
  end

  // set wins over the clear
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      done_r <= 1'b0;
    end else if (stage_end) begin
      done_r <= 1'b1;
    end else if (req.wr && req.addr == STM_ADDR_CLEAR) begin
      done_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      stage_done_out <= 1'b0;
    end else begin
      stage_done_out <= done_r;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      rdata_out <= 16'h0000;
    end else if (req.rd) begin
      case (req.addr)
        STM_ADDR_CTRL: rdata_out <= {15'h0000, run_r};
        STM_ADDR_NONOVERLAP: rdata_out <= nonoverlap_compare_ch0_r;
        STM_ADDR_STATUS: rdata_out <= {9'h000, stage_r, 1'b0, done_r, dir_rev_r, run_r};
        STM_ADDR_COUNT: rdata_out <= {6'h00, count_r};
        STM_ADDR_PERIOD: rdata_out <= step_period_compare_ch0_r;
        STM_ADDR_PATTERN: rdata_out <= {next_output_pattern_r[3:0], 4'h0, 4'h0, phase_r};
        default: rdata_out <= 16'h0000;
      endcase
    end else begin
      rdata_out <= 16'h0000;
    end
  end

endmodule : stm_sequencer

// file: bench/stm_sequencer_props.sv
`timescale 1ns/10ps
module stm_sequencer_props import stm_pkg::*; (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [7:0] addr_in,
  input wire logic [15:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic [15:0] rdata_out,
  input wire logic [3:0] phase_output_pins_out,
  input wire logic stage_done_out
);
  // =====
  // gap tracking
  logic [15:0] nov_r;
  logic [15:0] gap_r;
  logic pend_r;
  logic [3:0] prev_r;
  wire [3:0] ph = phase_output_pins_out;
  wire [3:0] fell = prev_r & ~ph;
  wire [3:0] rise = ph & ~prev_r;
  wire clr_w = wr_in && addr_in == STM_ADDR_CLEAR;
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      nov_r <= STM_NONOVERLAP_RST;
      prev_r <= 4'h0;
      pend_r <= 1'b0;
      gap_r <= 16'h0;
    end else begin
      prev_r <= ph;
      if (wr_in && addr_in == STM_ADDR_NONOVERLAP) nov_r <= wdata_in;
      if (|fell) begin
        pend_r <= 1'b1;
        gap_r <= 16'h1;
      end else if (|rise) pend_r <= 1'b0;
      else gap_r <= gap_r + 16'h1;
    end
  end
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  // =====
  // assertions
  AST_RESET_ZERO: assert property (disable iff (1'b0) rst_in |=>
    ph == 4'h0 && rdata_out == 16'h0 && !stage_done_out) else $error("outputs not cleared by reset");
  AST_PAIR_SET: assert property (!(ph inside {4'h5, 4'h7, 4'ha, 4'hb, 4'hd, 4'he, 4'hf}))
    else $error("phases energised are not adjacent");
  AST_NO_OVERLAP: assert property (|rise |-> fell == 4'h0)
    else $error("phase rose while another fell");
  AST_GAP_ONE: assert property (|fell |-> $countones(ph) == 1)
    else $error("falling edge did not leave one phase");
  // the counter's clearing tick adds one cycle to the gap
  AST_GAP_LEN: assert property (|rise && pend_r |-> gap_r == nov_r + 16'h1)
    else $error("gap length differs from compare value");
  AST_GAP_QUIET: assert property (pend_r && !(|rise) |-> $countones(ph) == 1)
    else $error("pins moved inside the gap");
  AST_DONE_STICKY: assert property (stage_done_out && !clr_w && !$past(clr_w) && !$past(clr_w, 2)
    |=> stage_done_out) else $error("stage flag dropped without clear");
  AST_NOV_READ: assert property (rd_in && addr_in == STM_ADDR_NONOVERLAP |=> rdata_out == nov_r)
    else $error("gap compare readback wrong");
  cover property (|fell);
  cover property (|rise && pend_r);
  cover property ($rose(stage_done_out));
endmodule : stm_sequencer_props
bind stm_sequencer stm_sequencer_props i_props (.clk_in(clk_in), .rst_in(rst_in), .addr_in(addr_in),
  .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
  .phase_output_pins_out(phase_output_pins_out), .stage_done_out(stage_done_out));

// file: bench/stm_driver_model.sv
`timescale 1ns/10ps
module stm_driver_model (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [3:0] phase_in,
  output int fwd_out,
  output int rev_out,
  output int bad_out
);
  // =====
  // winding pair tracking
  logic [3:0] pair_r;
  function automatic int slot(input logic [3:0] p);
    slot = (p == 4'h6) ? 0 : (p == 4'h3) ? 1 : (p == 4'h9) ? 2 : 3;
  endfunction : slot
  // a high pin energises its winding; only full pairs count as a step
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      pair_r <= 4'h0;
      fwd_out <= 0;
      rev_out <= 0;
      bad_out <= 0;
    end else if ($countones(phase_in) == 2 && phase_in != pair_r) begin
      pair_r <= phase_in;
      if (pair_r != 4'h0 && slot(phase_in) == (slot(pair_r) + 1) % 4) fwd_out <= fwd_out + 1;
      else if (pair_r != 4'h0 && slot(pair_r) == (slot(phase_in) + 1) % 4) rev_out <= rev_out + 1;
      else if (pair_r != 4'h0) bad_out <= bad_out + 1;
    end
  end
endmodule : stm_driver_model

// file: bench/test_stepper_two_phase_sequencer.sv
`timescale 1ns/10ps
module test_stepper_two_phase_sequencer;
  import stm_pkg::*;
  logic clk_in, rst_in, wr_in, rd_in, stage_done_out;
  logic [7:0] addr_in;
  logic [15:0] wdata_in, rdata_out, v;
  logic [3:0] phase_output_pins_out;
  int fwd, rev, bad, fail_count, checked;
  stm_sequencer i_dut (.clk_in(clk_in), .rst_in(rst_in), .addr_in(addr_in), .wdata_in(wdata_in),
    .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .phase_output_pins_out(phase_output_pins_out),
    .stage_done_out(stage_done_out));
  stm_driver_model i_drv (.clk_in(clk_in), .rst_in(rst_in), .phase_in(phase_output_pins_out),
    .fwd_out(fwd), .rev_out(rev), .bad_out(bad));
  initial begin
    clk_in = 1'b0;
    forever #25 clk_in = ~clk_in;
  end
  // =====
  // helpers
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task end_sim;
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : end_sim
  task tmo;
    fail_count++;
    $display("[ERR] %0t wait ran out", $time);
    end_sim();
  endtask : tmo
  task wr(input logic [7:0] a, input logic [15:0] d);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
    @(posedge clk_in);
  endtask : wr
  task rd(input logic [7:0] a, output logic [15:0] d);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
    @(negedge clk_in);
    d = rdata_out;
    @(posedge clk_in);
  endtask : rd
  // =====
  // scenarios
  task t_reset;
    chk({12'h0, phase_output_pins_out}, 16'h0);
    rd(STM_ADDR_NONOVERLAP, v);
    chk(v, STM_NONOVERLAP_RST);
    rd(8'h1c, v);
    chk(v, 16'h0);
    rd(STM_ADDR_CTRL, v);
    chk(v, 16'h0);
    rd(STM_ADDR_COUNT, v);
    chk(v, 16'h0);
    rd(STM_ADDR_PERIOD, v);
    chk(v, STM_PERIOD_RST);
    rd(STM_ADDR_PATTERN, v);
    chk(v, {STM_PAT0[3:0], 12'h000});
    $display("reset test done");
  endtask : t_reset
  task t_setup;
    wr(STM_ADDR_NONOVERLAP, 16'h0005);
    for (int i = 0; i < 49; i++) wr(8'(STM_ADDR_TABLE + 8'(2 * i)), 16'(60 - i));
    rd(STM_ADDR_NONOVERLAP, v);
    chk(v, 16'h0005);
    $display("setup test done");
  endtask : t_setup
  task t_first;
    int n;
    wr(STM_ADDR_CTRL, 16'h0001);
    for (n = 0; n < 2000 && phase_output_pins_out === 4'h0; n++) @(posedge clk_in);
    if (n == 2000) tmo();
    @(negedge clk_in);
    // the first activation replaces the preset pattern before any period match
    chk({12'h0, phase_output_pins_out}, {12'h0, STM_PAT1[3:0]});
    @(posedge clk_in);
    rd(STM_ADDR_CTRL, v);
    chk(v, 16'h0001);
    rd(STM_ADDR_COUNT, v);
    chk(v, 16'(STM_RAMP_STEP_COUNT - 10'd2));
    rd(STM_ADDR_PERIOD, v);
    chk(v, 16'h003b);
    rd(STM_ADDR_PATTERN, v);
    chk(v, {STM_PAT2[3:0], 8'h00, STM_PAT1[3:0]});
    $display("first step test done");
  endtask : t_first
  task t_cycle;
    logic [3:0] exp [9] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h9, 4'ha, 4'hb, 4'hc, 4'h1};
    logic [3:0] last, cur;
    int k, n;
    bit cleared;
    last = 4'h0;
    k = 0;
    cleared = 1'b0;
    for (n = 0; n < 40000 && k < 9; n++) begin
      rd(STM_ADDR_STATUS, v);
      cur = {v[STM_STAT_DIR_BIT], v[STM_STAT_STAGE_LSB +: 3]};
      if (cur != last) begin
        chk({12'h0, cur}, {12'h0, exp[k]});
        k++;
        last = cur;
      end
      if (stage_done_out === 1'b1 && !cleared) begin
        chk({15'h0, v[STM_STAT_DONE_BIT]}, 16'h1);
        wr(STM_ADDR_CLEAR, 16'h0);
        repeat (2) @(posedge clk_in);
        @(negedge clk_in);
        chk({15'h0, stage_done_out}, 16'h0);
        @(posedge clk_in);
        cleared = 1'b1;
      end
    end
    if (k < 9) tmo();
    $display("stage cycle test done");
  endtask : t_cycle
  task t_steps;
    chk(16'(bad), 16'h0);
    chk({15'h0, fwd > 500}, 16'h1);
    chk({15'h0, rev > 500}, 16'h1);
    $display("step count test done");
  endtask : t_steps
  initial begin
    rst_in = 1'b1;
    wr_in = 1'b0;
    rd_in = 1'b0;
    addr_in = 8'h00;
    wdata_in = 16'h0000;
    fail_count = 0;
    checked = 0;
    repeat (2) @(posedge clk_in);
    rst_in <= 1'b0;
    t_reset();
    t_setup();
    t_first();
    t_cycle();
    t_steps();
    end_sim();
  end
endmodule : test_stepper_two_phase_sequencer
